/* File: shared/channel_router_pkg.sv */
// channel_router_pkg: constants, types and helpers for the B-channel router.
// assumes: one clock, bytes exchanged once per frame on a frame strobe.
package channel_router_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_CH = 8;
  localparam int NUM_ROUTES = 3;
  localparam int BYTE_W = 8;

  // ==========================================================
  // channel codes held in each nibble of a route-select register
  typedef logic [3:0] chan_code_type;
  localparam chan_code_type CODE_NONE = 4'h0;
  localparam chan_code_type CODE_LINE_ONE = 4'h1;
  localparam chan_code_type CODE_LINE_TWO = 4'h2;
  localparam chan_code_type CODE_AUDIO = 4'h3;
  localparam chan_code_type CODE_HOST_ONE = 4'h4;
  localparam chan_code_type CODE_HOST_TWO = 4'h5;
  localparam chan_code_type CODE_PERIPH_ONE = 4'h6;
  localparam chan_code_type CODE_PERIPH_TWO = 4'h7;
  localparam chan_code_type CODE_PERIPH_THREE = 4'h8;

  // ==========================================================
  // channel indices on the byte buses (index = code - 1)
  typedef logic [2:0] chan_index_type;
  localparam chan_index_type IDX_LINE_ONE = 3'h0;
  localparam chan_index_type IDX_LINE_TWO = 3'h1;
  localparam chan_index_type IDX_AUDIO = 3'h2;
  localparam chan_index_type IDX_HOST_ONE = 3'h3;
  localparam chan_index_type IDX_HOST_TWO = 3'h4;
  localparam chan_index_type IDX_PERIPH_ONE = 3'h5;
  localparam chan_index_type IDX_PERIPH_TWO = 3'h6;
  localparam chan_index_type IDX_PERIPH_THREE = 3'h7;

  // ==========================================================
  // indirect register addresses and reset values
  localparam logic [7:0] ADDR_ROUTE_FIRST = 8'h41;
  localparam logic [7:0] ADDR_ROUTE_SECOND = 8'h42;
  localparam logic [7:0] ADDR_ROUTE_THIRD = 8'h43;
  localparam logic [7:0] ADDR_HOST_OPTIONS = 8'h44;
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic [7:0] OPTIONS_RESET = 8'h00;
  localparam logic [7:0] OPTIONS_WRITABLE = 8'h38;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ==========================================================
  // register layouts
  typedef struct packed {
    chan_code_type port_one;
    chan_code_type port_two;
  } route_select_type;

  typedef struct packed {
    logic [1:0] reserved_high;
    logic reverse_two;
    logic reverse_one;
    logic byte_irq_enable;
    logic [2:0] reserved_low;
  } host_options_type;

  // ==========================================================
  // carriers
  typedef logic [NUM_CH-1:0][BYTE_W-1:0] chan_bytes_type;

  typedef struct packed {
    logic active;
    chan_index_type source;
  } route_pick_type;

  typedef route_pick_type [NUM_CH-1:0] route_picks_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_request_type;

  // ==========================================================
  // helpers
  function automatic logic code_valid(input chan_code_type code);
    return (code >= CODE_LINE_ONE) && (code <= CODE_PERIPH_THREE);
  endfunction : code_valid

  function automatic chan_index_type code_index(input chan_code_type code);
    chan_code_type diff;
    diff = code - CODE_LINE_ONE;
    return diff[2:0];
  endfunction : code_index

  function automatic logic [BYTE_W-1:0] reverse_byte(input logic [BYTE_W-1:0] value);
    logic [BYTE_W-1:0] flipped;
    flipped = '0;
    for (int i = 0; i < BYTE_W; i++) begin
      flipped[i] = value[BYTE_W-1-i];
    end
    return flipped;
  endfunction : reverse_byte

endpackage : channel_router_pkg

/* File: core/route_resolver.sv */
// route_resolver: picks, for every destination channel, the source that feeds it.
// assumes: route registers are stable, purely combinational.
`timescale 1ns/1ps
`default_nettype none
module route_resolver
  import channel_router_pkg::*;
(
  input wire route_select_type route_first,
  input wire route_select_type route_second,
  input wire route_select_type route_third,
  output route_picks_type picks
);

  route_select_type ranked [NUM_ROUTES];

  assign ranked[0] = route_first; // RL2
  assign ranked[1] = route_second;
  assign ranked[2] = route_third;

  // ==========================================================
  // resolve, lowest rank first so later ranks overwrite
  always_comb begin
    picks = '0;
    for (int r = 0; r < NUM_ROUTES; r++) begin // RL4
      // both ends must decode; other codes move nothing
      if (code_valid(ranked[r].port_one) && code_valid(ranked[r].port_two)) begin // RL18
        // port two feeds port one, port one feeds port two
        picks[code_index(ranked[r].port_one)].active = 1'b1; // RL5
        picks[code_index(ranked[r].port_one)].source = code_index(ranked[r].port_two); // RL9
        // same code on both ends gives a loopback
        picks[code_index(ranked[r].port_two)].active = 1'b1; // RL6
        picks[code_index(ranked[r].port_two)].source = code_index(ranked[r].port_one); // RL8
      end
    end
  end

endmodule : route_resolver
`default_nettype wire

/* File: core/channel_router.sv */
// channel_router: time-slot router for eight 64 kbit/s B channels.
// assumes: one byte per channel offered each frame with frame_sync high one cycle;
// register requests arrive on the indirect register port, synchronous to clock.
//
// How it works
// RL1: eight channels: two line, one audio, two host, three peripheral.
// RL2: each route register holds one path; port one high nibble, port two low.
// RL3: codes 1..8 pick line, audio, host, peripheral channels; zero means none.
// RL4: both nibbles of all three route registers use the same codes.
// RL5: a path is two-way; each end receives what the other sends.
// RL6: equal codes in both nibbles loop a channel back to itself.
// RL7: third route register ranks highest, then second, then first.
// RL8: a destination fed by several paths takes the highest-ranked one only.
// RL9: one source may feed several destinations through several registers.
// RL10: options bit 3 enables the host byte-available interrupt; clear masks it.
// RL11: options bit 4 makes host channel one least significant bit first.
// RL12: options bit 5 makes host channel two least significant bit first.
// RL13: software writes zero to options bits 0 to 2, 6 and 7.
// RL14: route registers read and write at indirect 41H, 42H and 43H.
// RL15: options register reads and writes at indirect 44H.
// RL16: each routed channel carries one full-duplex 64 kbit/s byte stream.
// RL17: audio samples pass unchanged, sign bit first.
// RL18: codes 9 to 15 count as no connection and move nothing.
// RL19: one byte per routed channel per frame; unrouted destinations get nothing.
`timescale 1ns/1ps
`default_nettype none
module channel_router
  import channel_router_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire reg_request_type reg_request,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic frame_sync,
  input wire chan_bytes_type chan_tx,
  output chan_bytes_type chan_rx,
  output logic [NUM_CH-1:0] chan_rx_valid,
  output logic [NUM_CH-1:0] route_active,
  output logic host_byte_irq
);

  // ==========================================================
  // register file state
  route_select_type route_first;
  route_select_type route_second;
  route_select_type route_third;
  host_options_type host_options;
  route_select_type next_route_first;
  route_select_type next_route_second;
  route_select_type next_route_third;
  host_options_type next_host_options;
  logic [7:0] next_reg_rdata;
  logic next_reg_rvalid;

  // ==========================================================
  // data path state
  chan_bytes_type next_chan_rx;
  logic [NUM_CH-1:0] next_chan_rx_valid;
  logic [NUM_CH-1:0] next_route_active;
  logic next_host_byte_irq;

  route_picks_type picks;
  chan_bytes_type ingress;

  // ==========================================================
  // register writes and reads
  always_comb begin
    next_route_first = route_first;
    next_route_second = route_second;
    next_route_third = route_third;
    next_host_options = host_options;
    next_reg_rdata = reg_rdata;
    next_reg_rvalid = 1'b0;
    if (reg_request.write) begin
      unique case (reg_request.addr)
        ADDR_ROUTE_FIRST: next_route_first = reg_request.wdata; // RL14
        ADDR_ROUTE_SECOND: next_route_second = reg_request.wdata; // RL14
        ADDR_ROUTE_THIRD: next_route_third = reg_request.wdata; // RL14
        // reserved bits are not stored, so they read back as zero
        ADDR_HOST_OPTIONS: next_host_options = reg_request.wdata & OPTIONS_WRITABLE; // RL15
        default: begin
        end
      endcase
    end
    if (reg_request.read) begin
      next_reg_rvalid = 1'b1;
      unique case (reg_request.addr)
        ADDR_ROUTE_FIRST: next_reg_rdata = route_first; // RL14
        ADDR_ROUTE_SECOND: next_reg_rdata = route_second; // RL14
        ADDR_ROUTE_THIRD: next_reg_rdata = route_third; // RL14
        ADDR_HOST_OPTIONS: next_reg_rdata = host_options; // RL15
        default: next_reg_rdata = READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      route_first <= ROUTE_RESET; // RL3
      route_second <= ROUTE_RESET; // RL3
      route_third <= ROUTE_RESET; // RL3
      host_options <= OPTIONS_RESET; // RL10
      reg_rdata <= READ_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else begin
      route_first <= next_route_first;
      route_second <= next_route_second;
      route_third <= next_route_third;
      host_options <= next_host_options;
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

  // ==========================================================
  // path resolution, third register ranks highest
  route_resolver resolver (
    .route_first(route_first), // RL7
    .route_second(route_second), // RL7
    .route_third(route_third), // RL7
    .picks(picks)
  );

  // ==========================================================
  // ingress: host channels in lsb-first order are turned to msb-first
  always_comb begin
    ingress = chan_tx; // RL17
    if (host_options.reverse_one) begin
      ingress[IDX_HOST_ONE] = reverse_byte(chan_tx[IDX_HOST_ONE]); // RL11
    end
    if (host_options.reverse_two) begin
      ingress[IDX_HOST_TWO] = reverse_byte(chan_tx[IDX_HOST_TWO]); // RL12
    end
  end

  // ==========================================================
  // per-frame byte move and egress reversal
  always_comb begin
    next_chan_rx = chan_rx;
    next_chan_rx_valid = '0;
    for (int d = 0; d < NUM_CH; d++) begin
      next_route_active[d] = picks[d].active;
    end
    if (frame_sync) begin
      for (int d = 0; d < NUM_CH; d++) begin
        // unrouted destinations keep their last byte and see no strobe
        if (picks[d].active) begin // RL19
          next_chan_rx[d] = ingress[picks[d].source]; // RL16
          next_chan_rx_valid[d] = 1'b1; // RL1
        end
      end
      // only a fresh byte is turned; a held byte stays as delivered
      if (host_options.reverse_one && picks[IDX_HOST_ONE].active) begin
        next_chan_rx[IDX_HOST_ONE] = reverse_byte(next_chan_rx[IDX_HOST_ONE]); // RL11
      end
      if (host_options.reverse_two && picks[IDX_HOST_TWO].active) begin
        next_chan_rx[IDX_HOST_TWO] = reverse_byte(next_chan_rx[IDX_HOST_TWO]); // RL12
      end
    end
    // byte available towards the host, gated by the enable
    next_host_byte_irq = host_options.byte_irq_enable
      && (next_chan_rx_valid[IDX_HOST_ONE] || next_chan_rx_valid[IDX_HOST_TWO]); // RL10
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      chan_rx <= '0;
      chan_rx_valid <= '0;
      route_active <= '0;
      host_byte_irq <= 1'b0;
    end else begin
      chan_rx <= next_chan_rx;
      chan_rx_valid <= next_chan_rx_valid;
      route_active <= next_route_active;
      host_byte_irq <= next_host_byte_irq;
    end
  end

endmodule : channel_router
`default_nettype wire

/* File: verif/channel_router_props.sv */
// channel_router_props: port-level checks of the B-channel router.
// assumes: bound to channel_router, single clock, resetn synchronous active low.
`timescale 1ns/1ps
`default_nettype none
module channel_router_props
  import channel_router_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire reg_request_type reg_request,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic frame_sync,
  input wire chan_bytes_type chan_tx,
  input wire chan_bytes_type chan_rx,
  input wire logic [NUM_CH-1:0] chan_rx_valid,
  input wire logic [NUM_CH-1:0] route_active,
  input wire logic host_byte_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic mapped;
  assign mapped = reg_request.addr >= ADDR_ROUTE_FIRST && reg_request.addr <= ADDR_HOST_OPTIONS;
  // ==========================================================
  // assertions
  a_read_answered: assert property (reg_request.read |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_request.read))
    else $error("read answer without read");
  a_unmapped_zero: assert property (reg_request.read && !mapped |=> reg_rdata == READ_UNMAPPED)
    else $error("unmapped read not zero");
  a_options_masked: assert property (reg_request.read && reg_request.addr == ADDR_HOST_OPTIONS
    |=> (reg_rdata & ~OPTIONS_WRITABLE) == 8'h00)
    else $error("reserved option bits read back");
  a_valid_cause: assert property (|chan_rx_valid |-> $past(frame_sync))
    else $error("delivery without frame");
  a_valid_routes: assert property (frame_sync && !$past(reg_request.write)
    |=> chan_rx_valid == $past(route_active))
    else $error("delivery mask differs from routed set");
  a_irq_cause: assert property (host_byte_irq |-> $past(frame_sync)
    && (chan_rx_valid[IDX_HOST_ONE] || chan_rx_valid[IDX_HOST_TWO]))
    else $error("host irq without host delivery");
  a_rx_holds: assert property (chan_rx_valid == '0 |-> $stable(chan_rx))
    else $error("channel byte moved without delivery");
  a_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without read");
  a_path_active: assert property (reg_request.write && reg_request.addr == ADDR_ROUTE_FIRST
    && reg_request.wdata == 8'h14 ##1 !reg_request.write
    |=> route_active[IDX_LINE_ONE] && route_active[IDX_HOST_ONE])
    else $error("written path not active");
  c_host_irq: cover property (host_byte_irq);
  c_unmapped: cover property (reg_request.read && !mapped);
  c_priority: cover property (chan_rx_valid == 8'h0D);
endmodule : channel_router_props
bind channel_router channel_router_props channel_router_props_i (.clock(clock), .resetn(resetn),
  .reg_request(reg_request), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .frame_sync(frame_sync), .chan_tx(chan_tx), .chan_rx(chan_rx),
  .chan_rx_valid(chan_rx_valid), .route_active(route_active), .host_byte_irq(host_byte_irq));
`default_nettype wire

/* File: verif/channel_partner.sv */
// channel_partner: the eight channel sources offering one byte each frame.
// assumes: go is driven off the clock edge by the bench, one cycle per frame.
`timescale 1ns/1ps
`default_nettype none
module channel_partner
  import channel_router_pkg::*;
(
  input wire logic go,
  input wire logic [7:0] base,
  output logic frame_sync,
  output chan_bytes_type chan_tx
);
  // bytes outside a frame are inverted so stale data never matches
  always_comb begin
    frame_sync = go;
    for (int i = 0; i < NUM_CH; i++) begin
      chan_tx[i] = base + 8'(8'h11 * i);
      if (!go)
        chan_tx[i] = ~chan_tx[i];
    end
  end
endmodule : channel_partner
`default_nettype wire

/* File: verif/channel_router_test.sv */
// channel_router_test: directed scenarios for the B-channel router.
// assumes: channel_partner supplies frames, props are bound to the router.
`timescale 1ns/1ps
`default_nettype none
module channel_router_test;
  import channel_router_pkg::*;
  logic clock, resetn, go, reg_rvalid, frame_sync, host_byte_irq;
  logic [7:0] base, reg_rdata;
  reg_request_type req;
  chan_bytes_type chan_tx, chan_rx;
  logic [NUM_CH-1:0] chan_rx_valid, route_active;
  int errors, n_tests;
  channel_partner channel_partner_i (.go(go), .base(base), .frame_sync(frame_sync),
    .chan_tx(chan_tx));
  channel_router channel_router_i (.clock(clock), .resetn(resetn), .reg_request(req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .frame_sync(frame_sync),
    .chan_tx(chan_tx), .chan_rx(chan_rx), .chan_rx_valid(chan_rx_valid),
    .route_active(route_active), .host_byte_irq(host_byte_irq));
  always #4 clock = ~clock;
  // ==========================================================
  // helpers
  task automatic wrap_up;
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] pat(input int i);
    return base + 8'(8'h11 * i);
  endfunction : pat
  function automatic logic [7:0] flip(input logic [7:0] v);
    logic [7:0] f;
    for (int i = 0; i < 8; i++) f[i] = v[7-i];
    return f;
  endfunction : flip
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) #1 req = '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clock) #1 req.write = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock) #1 req = '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clock) #1 req.read = 1'b0;
    check("rvalid", {7'h0, reg_rvalid}, 8'h01);
    check("rdata", reg_rdata, exp);
  endtask : rd
  task automatic frame(input logic [7:0] b, input logic [7:0] vmask, input logic irq);
    @(posedge clock) #1 go = 1'b1;
    base = b;
    @(posedge clock) #1 go = 1'b0;
    check("rx_valid", chan_rx_valid, vmask);
    check("irq", {7'h0, host_byte_irq}, {7'h0, irq});
  endtask : frame
  task automatic rx(input int i, input logic [7:0] exp);
    check("rx", chan_rx[i], exp);
  endtask : rx
  // ==========================================================
  // scenarios
  task automatic test_reset;
    for (int a = 8'h41; a <= 8'h44; a++) rd(8'(a), 8'h00);
    frame(8'h00, 8'h00, 1'b0);
  endtask : test_reset
  task automatic test_regs;
    wr(8'h41, 8'h5A);
    wr(8'h42, 8'hC3);
    wr(8'h43, 8'h0F);
    wr(8'h45, 8'hFF);
    rd(8'h41, 8'h5A);
    rd(8'h42, 8'hC3);
    rd(8'h43, 8'h0F);
    rd(8'h45, 8'h00);
    rd(8'h40, 8'h00);
    wr(8'h44, 8'hFF);
    rd(8'h44, 8'h38);
  endtask : test_regs
  task automatic test_paths;
    wr(8'h44, 8'h00);
    wr(8'h41, 8'h14);
    wr(8'h42, 8'h23);
    wr(8'h43, 8'h00);
    frame(8'h20, 8'h0F, 1'b0);
    rx(0, pat(3));
    rx(3, pat(0));
    rx(1, pat(2));
    rx(2, pat(1));
  endtask : test_paths
  task automatic test_priority;
    wr(8'h41, 8'h00);
    wr(8'h42, 8'h14);
    wr(8'h43, 8'h43);
    frame(8'h40, 8'h0D, 1'b0);
    rx(0, pat(3));
    rx(2, pat(3));
    rx(3, pat(2));
    rx(1, 8'h42);
    check("route_active", route_active, 8'h0D);
  endtask : test_priority
  task automatic test_loop;
    wr(8'h41, 8'h96);
    wr(8'h42, 8'h22);
    wr(8'h43, 8'h33);
    frame(8'h60, 8'h06, 1'b0);
    rx(1, pat(1));
    rx(2, pat(2));
    check("route_active", route_active, 8'h06);
    wr(8'h41, 8'h68);
    frame(8'hA0, 8'hA6, 1'b0);
    rx(5, pat(7));
    rx(7, pat(5));
  endtask : test_loop
  task automatic test_reverse;
    wr(8'h44, 8'h18);
    wr(8'h41, 8'h14);
    wr(8'h42, 8'h00);
    wr(8'h43, 8'h00);
    frame(8'h80, 8'h09, 1'b1);
    rx(3, flip(pat(0)));
    rx(0, flip(pat(3)));
    wr(8'h44, 8'h30);
    wr(8'h41, 8'h57);
    frame(8'hC0, 8'h50, 1'b0);
    rx(4, flip(pat(6)));
    rx(6, flip(pat(4)));
    rx(3, 8'h01);
  endtask : test_reverse
  task automatic test_midreset;
    @(posedge clock) #1 resetn = 1'b0;
    repeat (2) @(posedge clock);
    #1 resetn = 1'b1;
    test_reset();
  endtask : test_midreset
  // ==========================================================
  // main sequence and watchdog
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    go = 1'b0;
    base = 8'h00;
    req = '0;
    errors = 0;
    n_tests = 0;
    repeat (10) @(posedge clock);
    #1 resetn = 1'b1;
    test_reset();
    test_regs();
    test_paths();
    test_priority();
    test_loop();
    test_reverse();
    test_midreset();
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    wrap_up();
  end
endmodule : channel_router_test
`default_nettype wire
